/* rtl/ijx_regs.svh */
// constants for the insert and jump execution unit
`ifndef IJX_REGS_SVH
`define IJX_REGS_SVH
`define IJX_OP_INSERT_BYTE       8'h0C
`define IJX_OP_INSERT_HALF       8'h78
`define IJX_OP_CACHE_CLR         8'h9F
`define IJX_OP_INT_RETURN        8'h88
`define IJX_OP_INT_RETURN_CLR    8'h8C
`define IJX_OP_DIRECT_JUMP       8'hA0
`define IJX_OP_JUMP_FALSE        8'hA4
`define IJX_OP_JUMP_FALSE_DEC    8'hB4
`define IJX_OP_JUMP_FALSE_IND    8'hC4
`define IJX_DESTINATION_REG_MSB             23
`define IJX_DESTINATION_REG_LSB             16
`define IJX_FIRST_REG_MSB        15
`define IJX_FIRST_REG_LSB        8
`define IJX_LOW_FIELD_MSB        7
`define IJX_LOW_FIELD_LSB        0
`define IJX_OPC_MSB       31
`define IJX_OPC_LSB       24
`define IJX_MODE_BIT      24
`define IJX_TGT_WIDTH     30
`define IJX_WORD_RESET    32'h0000_0000
`define IJX_BTC_ENTRIES   32
`endif

/* rtl/ijx_pkg.sv */
// types shared by the insert and jump execution unit
package ijx_pkg;
    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] first_operand;
        logic [31:0] reg_second;
        logic [29:0] pc;
        logic [1:0]  byte_position_field;
        logic        byte_order;
        logic        supervisor;
        logic        valid;
    } ijx_issue_t;

    typedef struct packed {
        logic        wr_en;
        logic [7:0]  destination_reg;
        logic [31:0] wr_data;
        logic        fetch_redirect;
        logic [29:0] fetch_target;
        logic        prot_trap;
        logic        interrupt_return_op_start;
    } ijx_result_t;

    typedef enum logic [1:0] {
        IJX_CLR_IDLE,
        IJX_CLR_PENDING
    } ijx_clr_state_t;
endpackage

/* rtl/ijx_exec.sv */
// insert, invalidate, interrupt return and jump execution
`timescale 1ns/1ps
`include "ijx_regs.svh"
module ijx_exec (
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire ijx_pkg::ijx_issue_t issue,
    input  wire logic                branch_taken_any,
    output ijx_pkg::ijx_result_t     result,
    output logic                     delay_slot_exec,
    output logic [`IJX_BTC_ENTRIES-1:0] btc_valid_clear,
    output logic                     btc_clear_pulse
);
    // decoded instruction fields
    logic [7:0]                  opc;
    logic [6:0]                  opc_key;
    logic                        mode_bit;
    logic [7:0]                  destination_reg_field;
    logic [7:0]                  first_reg_field;
    logic [7:0]                  low_field;

    // operands and merged words
    logic [31:0]                 second_operand;
    logic [1:0]                  lane;
    logic                        half_lane;
    logic [31:0]                 ins_byte;
    logic [31:0]                 ins_half;
    logic [31:0]                 dec_value;

    // jump targets and condition
    logic [15:0]                 imm16;
    logic [29:0]                 imm_sext;
    logic [29:0]                 imm_zext;
    logic [29:0]                 tgt_rel;
    logic [29:0]                 tgt;
    logic [29:0]                 tgt_ind;
    logic                        cond_true;
    logic                        cond_false;

    // opcode classes
    logic                        is_insert_byte;
    logic                        is_insert_half;
    logic                        is_cache_clr;
    logic                        is_int_return;
    logic                        is_int_return_clr;
    logic                        is_direct_jump;
    logic                        is_jump_false;
    logic                        is_jump_false_dec;
    logic                        is_jump_false_ind;
    logic                        is_cond_jump;
    logic                        privileged;
    logic                        user_trap;
    logic                        new_cache_clr;
    logic                        return_clr;

    // result group
    ijx_pkg::ijx_result_t        next_result;

    // delay slot group
    logic                        next_delay_slot_exec;

    // branch cache clear group
    ijx_pkg::ijx_clr_state_t     clr_state;
    ijx_pkg::ijx_clr_state_t     next_clr_state;
    logic                        next_btc_clear_pulse;
    logic [`IJX_BTC_ENTRIES-1:0] next_btc_valid_clear;

    genvar gi;

    // field split
    always_comb begin
        opc             = issue.instr[`IJX_OPC_MSB:`IJX_OPC_LSB];
        opc_key         = opc[7:1];
        mode_bit        = issue.instr[`IJX_MODE_BIT];
        destination_reg_field      = issue.instr[`IJX_DESTINATION_REG_MSB:`IJX_DESTINATION_REG_LSB];
        first_reg_field = issue.instr[`IJX_FIRST_REG_MSB:`IJX_FIRST_REG_LSB];
        low_field       = issue.instr[`IJX_LOW_FIELD_MSB:`IJX_LOW_FIELD_LSB];
    end

    // opcode classes, low opcode bit is the mode bit and is ignored
    always_comb begin
        is_insert_byte    = {opc_key, 1'b0} == `IJX_OP_INSERT_BYTE;
        is_insert_half    = {opc_key, 1'b0} == `IJX_OP_INSERT_HALF;
        is_cache_clr      = {opc_key, 1'b0} == {`IJX_OP_CACHE_CLR >> 1, 1'b0};
        is_int_return     = {opc_key, 1'b0} == `IJX_OP_INT_RETURN;
        is_int_return_clr = {opc_key, 1'b0} == `IJX_OP_INT_RETURN_CLR;
        is_direct_jump    = {opc_key, 1'b0} == `IJX_OP_DIRECT_JUMP;
        is_jump_false     = {opc_key, 1'b0} == `IJX_OP_JUMP_FALSE;
        is_jump_false_dec = {opc_key, 1'b0} == `IJX_OP_JUMP_FALSE_DEC;
        is_jump_false_ind = {opc_key, 1'b0} == `IJX_OP_JUMP_FALSE_IND;
        is_cond_jump      = is_jump_false || is_jump_false_dec || is_jump_false_ind;
        privileged        = is_cache_clr || is_int_return || is_int_return_clr;
        user_trap         = issue.valid && privileged && !issue.supervisor;
        new_cache_clr     = issue.valid && is_cache_clr && issue.supervisor;
        return_clr        = issue.valid && is_int_return_clr && issue.supervisor;
    end

    // operand selection
    always_comb begin
        // register or zero-extended immediate
        second_operand = mode_bit ? {24'h00_0000, low_field}
                                  : issue.reg_second;
        // big-endian order numbers bytes from the top
        lane      = issue.byte_order ? issue.byte_position_field
                                     : ~issue.byte_position_field;
        half_lane = lane[1];
        dec_value = issue.first_operand - 32'h0000_0001;
    end

    // byte and half-word merge, one lane per byte
    generate
        for (gi = 0; gi < 4; gi++) begin : g_byte_lane
            assign ins_byte[gi*8 +: 8] = (lane == 2'(gi)) ? second_operand[7:0]
                                                          : issue.first_operand[gi*8 +: 8];
            assign ins_half[gi*8 +: 8] = (half_lane == 1'(gi / 2))
                                         ? second_operand[(gi % 2)*8 +: 8]
                                         : issue.first_operand[gi*8 +: 8];
        end
    endgenerate

    // jump targets and tested condition
    always_comb begin
        imm16      = {destination_reg_field, low_field};
        imm_sext   = {{14{imm16[15]}}, imm16};
        imm_zext   = {14'h0000, imm16};
        tgt_rel    = issue.pc + imm_sext;
        tgt        = mode_bit ? imm_zext : tgt_rel;
        tgt_ind    = issue.reg_second[31:2];
        cond_true  = issue.first_operand[31];
        cond_false = !cond_true;
    end

    // result group, next value
    always_comb begin
        next_result = '0;
        if (issue.valid) begin
            if (is_insert_byte) begin
                next_result.wr_en           = 1'b1;
                next_result.destination_reg = destination_reg_field;
                next_result.wr_data         = ins_byte;
            end else if (is_insert_half) begin
                next_result.wr_en           = 1'b1;
                next_result.destination_reg = destination_reg_field;
                next_result.wr_data         = ins_half;
            end else if (is_direct_jump) begin
                next_result.fetch_redirect = 1'b1;
                next_result.fetch_target   = tgt;
            end else if (is_jump_false) begin
                next_result.fetch_redirect = cond_false;
                next_result.fetch_target   = tgt;
            end else if (is_jump_false_dec) begin
                next_result.fetch_redirect  = cond_false;
                next_result.fetch_target    = tgt;
                next_result.wr_en           = 1'b1;
                next_result.destination_reg = first_reg_field;
                next_result.wr_data         = dec_value;
            end else if (is_jump_false_ind) begin
                next_result.fetch_redirect = cond_false;
                next_result.fetch_target   = tgt_ind;
            end else if (user_trap) begin
                next_result.prot_trap = 1'b1;
            end else if (is_int_return || is_int_return_clr) begin
                next_result.interrupt_return_op_start = 1'b1;
            end
        end
    end

    // result group, registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            result <= '0;
        end else begin
            result <= next_result;
        end
    end

    // delay slot group, next value
    always_comb begin
        next_delay_slot_exec = 1'b0;
        if (issue.valid) begin
            if (is_direct_jump) begin
                next_delay_slot_exec = 1'b1;
            end
            if (is_cond_jump) begin
                next_delay_slot_exec = 1'b1;
            end
        end
    end

    // delay slot group, register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            delay_slot_exec <= 1'b0;
        end else begin
            delay_slot_exec <= next_delay_slot_exec;
        end
    end

    // branch cache clear group, next value
    always_comb begin
        next_clr_state       = clr_state;
        next_btc_clear_pulse = 1'b0;
        if (return_clr) begin
            next_btc_clear_pulse = 1'b1;
        end
        case (clr_state)
            ijx_pkg::IJX_CLR_IDLE: begin
                if (new_cache_clr) begin
                    next_clr_state = ijx_pkg::IJX_CLR_PENDING;
                end
            end
            ijx_pkg::IJX_CLR_PENDING: begin
                if (branch_taken_any) begin
                    next_btc_clear_pulse = 1'b1;
                    // a new request in the same cycle stays pending
                    if (!new_cache_clr) begin
                        next_clr_state = ijx_pkg::IJX_CLR_IDLE;
                    end
                end
            end
            default: begin
                next_clr_state = ijx_pkg::IJX_CLR_IDLE;
            end
        endcase
    end

    // one clear line per cache entry
    generate
        for (gi = 0; gi < `IJX_BTC_ENTRIES; gi++) begin : g_btc_entry
            assign next_btc_valid_clear[gi] = next_btc_clear_pulse;
        end
    endgenerate

    // branch cache clear group, registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clr_state       <= ijx_pkg::IJX_CLR_IDLE;
            btc_clear_pulse <= 1'b0;
            btc_valid_clear <= '0;
        end else begin
            clr_state       <= next_clr_state;
            btc_clear_pulse <= next_btc_clear_pulse;
            btc_valid_clear <= next_btc_valid_clear;
        end
    end
endmodule

/* sim/ijx_exec_properties.sv */
// assertions for the insert and jump execution unit
`timescale 1ns/1ps
module ijx_exec_properties (
    input wire logic                 mclk,
    input wire logic                 rstn,
    input wire ijx_pkg::ijx_issue_t  issue,
    input wire logic                 branch_taken_any,
    input wire ijx_pkg::ijx_result_t result,
    input wire logic                 delay_slot_exec,
    input wire logic [31:0]          btc_valid_clear,
    input wire logic                 btc_clear_pulse
);
    logic [6:0] k;
    assign k = issue.valid ? issue.instr[31:25] : 7'h7f;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_cache_clr;
        k == 7'h4f && issue.supervisor ##1 !issue.valid && branch_taken_any;
    endsequence
    property p_cache_clr; s_cache_clr |=> btc_clear_pulse && &btc_valid_clear; endproperty
    a_cache_clr: assert property (p_cache_clr) else $error("no clear on branch");
    property p_trap; k inside {7'h4f, 7'h44, 7'h46} && !issue.supervisor |=> result.prot_trap
        && !result.interrupt_return_op_start && !btc_clear_pulse; endproperty
    a_trap: assert property (p_trap) else $error("user op not trapped");
    property p_interrupt_return_op; (k == 7'h44 || k == 7'h46) && issue.supervisor |=> result.interrupt_return_op_start; endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("no return start");
    property p_clr; k == 7'h46 && issue.supervisor |=> btc_clear_pulse && &btc_valid_clear; endproperty
    a_clr: assert property (p_clr) else $error("no clear on return");
    property p_byte; k == 7'h06 && issue.byte_order && issue.byte_position_field == 2'h0
        |=> result.wr_data[31:8] == $past(issue.first_operand[31:8]); endproperty
    a_byte: assert property (p_byte) else $error("byte merge");
    property p_direct_jump; k == 7'h50 |=> result.fetch_redirect && delay_slot_exec; endproperty
    a_direct_jump: assert property (p_direct_jump) else $error("jump");
    property p_false_jump; k == 7'h52 |=> delay_slot_exec
        && result.fetch_redirect != $past(issue.first_operand[31]); endproperty
    a_false_jump: assert property (p_false_jump) else $error("false jump");
    property p_dec; k == 7'h5a |=> result.wr_data == $past(issue.first_operand) - 32'h0000_0001;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement");
    property p_jfi; k == 7'h62 && !issue.first_operand[31]
        |=> result.fetch_target == $past(issue.reg_second[31:2]); endproperty
    a_jfi: assert property (p_jfi) else $error("indirect target");
endmodule
bind ijx_exec ijx_exec_properties u_ijx_exec_properties (.mclk(mclk), .rstn(rstn),
    .issue(issue), .branch_taken_any(branch_taken_any), .result(result),
    .delay_slot_exec(delay_slot_exec), .btc_valid_clear(btc_valid_clear),
    .btc_clear_pulse(btc_clear_pulse));

/* sim/test_insert_and_jump_execution.sv */
// self-checking bench for the insert and jump execution unit
`timescale 1ns/1ps
module test_insert_and_jump_execution;
    logic                 mclk, rstn, branch_taken_any, delay_slot_exec, btc_clear_pulse;
    logic                 pend, on, hit, f, clr;
    logic [31:0]          btc_valid_clear, r, a, b;
    logic [29:0]          tg;
    logic [15:0]          im;
    logic [7:0]           op, ops [10];
    logic [1:0]           ln;
    ijx_pkg::ijx_issue_t  issue;
    ijx_pkg::ijx_result_t result, er;
    logic [107:0]         eq;
    int                   n_mismatch, checks;
    ijx_exec u_ijx_exec (.mclk(mclk), .rstn(rstn), .issue(issue), .branch_taken_any(branch_taken_any),
        .result(result), .delay_slot_exec(delay_slot_exec), .btc_valid_clear(btc_valid_clear),
        .btc_clear_pulse(btc_clear_pulse));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [107:0] e);
        checks++;
        if ({result, delay_slot_exec, btc_clear_pulse, btc_valid_clear} !== e) begin
            n_mismatch++;
            $display("[ERR] %0t outputs differ from model", $time);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (on) chk(eq);
        on = 1;
        er = '0;
        op = {issue.instr[31:25], 1'b0};
        a = issue.first_operand;
        b = issue.instr[24] ? {24'h00_0000, issue.instr[7:0]} : issue.reg_second;
        ln = issue.byte_order ? issue.byte_position_field : ~issue.byte_position_field;
        im = {issue.instr[23:16], issue.instr[7:0]};
        tg = issue.instr[24] ? {14'h0000, im} : issue.pc + {{14{im[15]}}, im};
        f = !a[31];
        hit = rstn && issue.valid;
        if (hit) case (op)
            8'h0C, 8'h78: begin
                er.wr_en = 1;
                er.destination_reg = issue.instr[23:16];
                er.wr_data = a;
                if (op[4]) er.wr_data[ln[1]*16 +: 16] = b[15:0];
                else er.wr_data[ln*8 +: 8] = b[7:0];
            end
            8'h9E, 8'h88, 8'h8C: begin
                er.prot_trap = !issue.supervisor;
                er.interrupt_return_op_start = issue.supervisor && op != 8'h9E;
            end
            8'hA0, 8'hA4, 8'hB4, 8'hC4: begin
                er.fetch_redirect = op == 8'hA0 || f;
                er.fetch_target = op == 8'hC4 ? issue.reg_second[31:2] : tg;
                if (op == 8'hB4) begin
                    er.wr_en = 1;
                    er.destination_reg = issue.instr[15:8];
                    er.wr_data = a - 32'h0000_0001;
                end
            end
            default: ;
        endcase
        clr = hit && op == 8'h8C && issue.supervisor || pend && branch_taken_any;
        eq = {er, hit && (op[7:5] == 3'h5 || op == 8'hC4), clr, {32{clr}}};
        pend = rstn && (hit && op == 8'h9E && issue.supervisor || pend && !branch_taken_any);
    end
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        #400_000;
        n_mismatch++;
        conclude();
    end
    initial begin
        ops = '{8'h0C, 8'h78, 8'h9F, 8'h88, 8'h8C, 8'hA0, 8'hA4, 8'hB4, 8'hC4, 8'h00};
        {rstn, branch_taken_any, on, pend} = '0;
        issue = '0;
        r = 32'h0000_2FB9;
        repeat (20) @(posedge mclk);
        rstn <= 1;
        for (int k = 0; k < 300; k++) begin
            r = lfsr(r);
            issue <= {ops[k % 10][7:1], r[24:0], lfsr(r), {r[15:0], r[31:16]}, r[29:0], r[26:25],
                r[27], r[28] | r[29], 1'b1};
            branch_taken_any <= 0;
            @(posedge mclk);
            if (ops[k % 10] == 8'h9F || r[31]) begin
                issue.valid <= 0;
                branch_taken_any <= ops[k % 10] == 8'h9F || r[30];
                @(posedge mclk);
            end
        end
        repeat (2) @(posedge mclk);
        conclude();
    end
endmodule
